// ==== hdl/adc_clk_div.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// divided converter clock tick
module adc_clk_div
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // control
    input  wire logic              run,
    input  wire logic [DIV_W-1:0]  divider,
    // tick out
    output logic                   tick
);
    logic [DIV_W:0] cnt_q;
    logic [DIV_W:0] last_w;
    // period is (divider+1)*2 ref clocks
    assign last_w = {divider, 1'b1};
    // count while running, tick on terminal count
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run || cnt_q == last_w) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign tick = run && (cnt_q == last_w);
endmodule : adc_clk_div
`default_nettype wire

// ==== hdl/adc_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// conversion sequencer and result/flag control
// Behaviour
// - sample-hold then ten divided clocks
// - divider zero is /2, 63 is /128
// - ten-bit default, eight-bit when selected
// - eight-bit results: upper two bits zero
// - dma size sixteen or eight bits
// - result into channel and last registers
// - enable/disable writes set/clear channel bits
// - done sets channel flag and ready
// - ready rising issues one dma request
// - channel read clears its done flag
// - last read clears ready, last done
// - unread channel result sets channel overrun
// - result while ready sets global overrun
// - status read clears all overrun flags
// - start write issues software start
// - select field chooses source, enable gates
// - rising edge of trigger starts
// - one start converts all enabled channels
// - software start works with hardware trigger
// - sleep: wake, convert, stop clock
// - sample-hold is field plus three
// - starts ignored while sequence running
// - wake waits programmed startup time
module adc_sequencer
    import adc_seq_pkg::*;
#(
    parameter int N_CH = NUM_CH
)
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // software control
    input  wire logic                    sw_start,
    input  wire mode_cfg_t               mode_cfg,
    input  wire logic [N_CH-1:0]         channel_enable_write,
    input  wire logic [N_CH-1:0]         channel_disable_write,
    input  wire logic [STAT_W-1:0]       irq_mask,
    // software read strobes
    input  wire logic [N_CH-1:0]         channel_result_rd,
    input  wire logic                    last_result_rd,
    input  wire logic                    status_rd,
    // hardware triggers
    input  wire logic [NUM_INT_TRIG-1:0] timer_wave_output,
    input  wire logic                    ext_trigger,
    // analog cell
    input  wire logic [RES_W-1:0]        cell_result,
    output logic                         cell_power_on,
    output logic                         cell_clk_en,
    output logic                         cell_sample,
    output logic [CH_IDX_W-1:0]          cell_channel,
    // results
    output logic [N_CH-1:0][RES_W-1:0]   channel_result_reg,
    output logic [RES_W-1:0]             last_result_value,
    output logic [CH_IDX_W-1:0]          last_channel,
    // status
    output logic [N_CH-1:0]              channel_enabled,
    output logic [N_CH-1:0]              channel_conv_done,
    output logic [N_CH-1:0]              channel_overrun_flag,
    output logic                         result_ready_flag,
    output logic                         global_overrun_flag,
    output logic                         busy,
    output logic                         irq,
    // dma
    output logic                         dma_req,
    output logic                         dma_size_16
);
    // ==========================================================
    // state and registers
    seq_state_t                 state_q, state_d;
    logic [CNT_W-1:0]           cnt_q, cnt_d;
    logic [CH_IDX_W-1:0]        ch_q, ch_d;
    logic [N_CH-1:0]            ch_en_q;
    logic [N_CH-1:0]            done_q;
    logic [N_CH-1:0]            ovr_q;
    logic                       result_ready_flag_q;
    logic                       global_overrun_flag_q;
    logic [N_CH-1:0][RES_W-1:0] cdr_q;
    logic [RES_W-1:0]           last_result_value_q;
    logic [CH_IDX_W-1:0]        lch_q;
    logic                       dma_req_q;
    logic                       dma16_q;
    logic                       irq_q;
    logic                       pwr_q;
    logic                       clk_en_q;
    logic                       sample_q;
    logic                       busy_q;
    logic                       awake_q;
    // ==========================================================
    // helper wires
    logic                       adc_tick;
    logic                       hw_start;
    logic                       start_w;
    logic                       store_w;
    logic [RES_W-1:0]           res_w;
    logic [N_CH-1:0]            store_sel_w;
    logic [N_CH-1:0]            pend_mask_w;
    logic                       any_pend_w;
    logic [CH_IDX_W-1:0]        next_ch_w;
    logic [CNT_W-1:0]           sh_len_w;
    logic [CNT_W-1:0]           su_len_w;
    logic [STAT_W-1:0]          stat_w;
    logic                       run_clk_w;

    // ==========================================================
    // submodules
    // divider runs only while the sequence needs the adc clock
    assign run_clk_w = (state_q == ST_WAKE) || (state_q == ST_SAMPLE)
                    || (state_q == ST_CONVERT);
    adc_clk_div u_div (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .run     (run_clk_w),
        .divider (mode_cfg.conv_clock_divider),
        .tick    (adc_tick)
    );
    adc_trig_detect u_trig (
        .ref_clk           (ref_clk),
        .sys_rst           (sys_rst),
        .timer_wave_output (timer_wave_output),
        .ext_trigger       (ext_trigger),
        .sel               (mode_cfg.trigger_source_sel),
        .enable            (mode_cfg.hw_trigger_enable),
        .start_req         (hw_start)
    );

    // ==========================================================
    // start, timing lengths and channel scan
    // either source may start, only from idle
    assign start_w  = (sw_start || hw_start)
                    && (state_q == ST_IDLE);
    assign sh_len_w = CNT_W'(mode_cfg.sample_hold_cycles)
                    + CNT_W'(SH_EXTRA);
    assign su_len_w = CNT_W'(mode_cfg.startup_time) * CNT_W'(STARTUP_MUL)
                    + CNT_W'(STARTUP_MUL);
    // channels not yet visited this sequence
    genvar gi;
    generate
        for (gi = 0; gi < N_CH; gi++) begin : g_pend
            assign pend_mask_w[gi] = ch_en_q[gi]
                                  && (CH_IDX_W'(gi) >= ch_q);
        end
    endgenerate
    assign any_pend_w = |pend_mask_w;
    // lowest pending channel first
    always_comb begin
        next_ch_w = '0;
        for (int i = N_CH - 1; i >= 0; i--) begin
            if (pend_mask_w[i]) begin
                next_ch_w = CH_IDX_W'(i);
            end
        end
    end

    // ==========================================================
    // sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        ch_d    = ch_q;
        case (state_q)
            ST_IDLE: begin
                ch_d = '0;
                if (start_w) begin
                    state_d = ST_PICK;
                end
            end
            ST_PICK: begin
                cnt_d = '0;
                if (!any_pend_w) begin
                    state_d = ST_IDLE;
                end else if (!awake_q) begin
                    ch_d    = next_ch_w;
                    state_d = ST_WAKE;
                end else begin
                    ch_d    = next_ch_w;
                    state_d = ST_SAMPLE;
                end
            end
            ST_WAKE: begin
                if (adc_tick) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q + 1'b1 >= su_len_w) begin
                        cnt_d   = '0;
                        state_d = ST_SAMPLE;
                    end
                end
            end
            ST_SAMPLE: begin
                if (adc_tick) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q + 1'b1 >= sh_len_w) begin
                        cnt_d   = '0;
                        state_d = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT: begin
                if (adc_tick) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q + 1'b1 >= CNT_W'(CONV_CYCLES)) begin
                        cnt_d   = '0;
                        state_d = ST_STORE;
                    end
                end
            end
            ST_STORE: begin
                // move past converted channel; wrap means done
                if (ch_q == CH_IDX_W'(N_CH - 1)) begin
                    state_d = ST_IDLE;
                end else begin
                    ch_d    = ch_q + 1'b1;
                    state_d = ST_PICK;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            ch_q    <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ch_q    <= ch_d;
        end
    end

    // ==========================================================
    // result path
    assign store_w = (state_q == ST_STORE);
    assign res_w   = mode_cfg.low_resolution_sel
                   ? {2'b00, cell_result[RES_W-3:0]}
                   : cell_result;
    // per channel data, done and overrun flags
    generate
        for (gi = 0; gi < N_CH; gi++) begin : g_ch
            assign store_sel_w[gi] = store_w && (ch_q == CH_IDX_W'(gi));
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    cdr_q[gi]  <= RESULT_RST;
                    done_q[gi] <= 1'b0;
                    ovr_q[gi]  <= 1'b0;
                    ch_en_q[gi] <= CH_EN_RST[gi];
                end else begin
                    if (store_sel_w[gi]) begin
                        cdr_q[gi] <= res_w;
                    end
                    // set wins over any clear
                    if (store_sel_w[gi]) begin
                        done_q[gi] <= 1'b1;
                    end else if (channel_result_rd[gi]
                              || (last_result_rd
                                  && lch_q == CH_IDX_W'(gi))) begin
                        done_q[gi] <= 1'b0;
                    end
                    if (store_sel_w[gi] && done_q[gi]) begin
                        ovr_q[gi] <= 1'b1;
                    end else if (status_rd) begin
                        ovr_q[gi] <= 1'b0;
                    end
                    if (channel_enable_write[gi]) begin
                        ch_en_q[gi] <= 1'b1;
                    end else if (channel_disable_write[gi]) begin
                        ch_en_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // shared last result, ready and global overrun
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            last_result_value_q <= RESULT_RST;
            lch_q   <= '0;
            result_ready_flag_q  <= 1'b0;
            global_overrun_flag_q <= 1'b0;
        end else begin
            if (store_w) begin
                last_result_value_q <= res_w;
                lch_q   <= ch_q;
            end
            if (store_w) begin
                result_ready_flag_q <= 1'b1;
            end else if (last_result_rd) begin
                result_ready_flag_q <= 1'b0;
            end
            if (store_w && result_ready_flag_q) begin
                global_overrun_flag_q <= 1'b1;
            end else if (status_rd) begin
                global_overrun_flag_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // dma, interrupt and cell control
    assign stat_w = {global_overrun_flag_q, result_ready_flag_q, ovr_q, done_q};
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dma_req_q <= 1'b0;
            dma16_q   <= 1'b1;
            irq_q     <= 1'b0;
            pwr_q     <= 1'b0;
            clk_en_q  <= 1'b0;
            sample_q  <= 1'b0;
            busy_q    <= 1'b0;
            awake_q   <= 1'b0;
        end else begin
            dma_req_q <= store_w && !result_ready_flag_q;
            dma16_q   <= !mode_cfg.low_resolution_sel;
            irq_q     <= |(stat_w & irq_mask);
            // cell stays powered outside sleep mode
            awake_q   <= !mode_cfg.sleep_mode
                       || (state_d == ST_SAMPLE)
                       || (state_d == ST_CONVERT)
                       || (state_d == ST_STORE)
                       || (state_d == ST_PICK && awake_q);
            pwr_q     <= (state_d != ST_IDLE) || !mode_cfg.sleep_mode;
            clk_en_q  <= (state_d == ST_WAKE) || (state_d == ST_SAMPLE)
                       || (state_d == ST_CONVERT);
            sample_q  <= (state_d == ST_SAMPLE);
            busy_q    <= (state_d != ST_IDLE);
        end
    end

    // ==========================================================
    // outputs
    assign cell_power_on        = pwr_q;
    assign cell_clk_en          = clk_en_q;
    assign cell_sample          = sample_q;
    assign cell_channel         = ch_q;
    assign channel_result_reg   = cdr_q;
    assign last_result_value    = last_result_value_q;
    assign last_channel         = lch_q;
    assign channel_enabled      = ch_en_q;
    assign channel_conv_done    = done_q;
    assign channel_overrun_flag = ovr_q;
    assign result_ready_flag    = result_ready_flag_q;
    assign global_overrun_flag  = global_overrun_flag_q;
    assign busy                 = busy_q;
    assign irq                  = irq_q;
    assign dma_req              = dma_req_q;
    assign dma_size_16          = dma16_q;
endmodule : adc_sequencer
`default_nettype wire

// ==== hdl/adc_trig_detect.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// trigger select and rising edge detect
module adc_trig_detect
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // trigger sources
    input  wire logic [NUM_INT_TRIG-1:0] timer_wave_output,
    input  wire logic                    ext_trigger,
    // selection
    input  wire logic [TSEL_W-1:0]       sel,
    input  wire logic                    enable,
    // start request pulse
    output logic                         start_req
);
    logic sel_lvl_w;
    logic prev_q;
    // codes 0..5 internal triggers, 6 external pin
    assign sel_lvl_w = (sel == TSEL_EXT) ? ext_trigger :
                       (sel < TSEL_W'(NUM_INT_TRIG)) ?
                       timer_wave_output[sel] : 1'b0;
    // remember previous level of selected source
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= sel_lvl_w;
        end
    end
    assign start_req = enable && sel_lvl_w && !prev_q;
endmodule : adc_trig_detect
`default_nettype wire

// ==== pkg/adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;
    // ==========================================================
    // sizes and field layout
    localparam int NUM_CH         = 8;
    localparam int RES_W          = 10;
    localparam int DIV_W          = 6;
    localparam int SH_W           = 4;
    localparam int SU_W           = 7;
    localparam int TSEL_W         = 3;
    localparam int NUM_INT_TRIG   = 6;
    localparam int CH_IDX_W       = 3;
    localparam int STAT_W         = 2 * NUM_CH + 2;
    // ==========================================================
    // timing constants
    localparam int CONV_CYCLES    = 10;  // adc clocks per conversion
    localparam int SH_EXTRA       = 3;   // added to sample hold field
    localparam int STARTUP_MUL    = 8;   // startup units of adc clocks
    localparam int CNT_W          = 11;  // holds the longest startup count
    // ==========================================================
    // trigger codes and reset values
    localparam logic [2:0] TSEL_EXT       = 3'h6;
    localparam logic [7:0] CH_EN_RST      = 8'h00;
    localparam logic [9:0] RESULT_RST     = 10'h000;
    // ==========================================================
    // mode settings travelling together
    typedef struct packed {
        logic [SH_W-1:0]   sample_hold_cycles;
        logic [SU_W-1:0]   startup_time;
        logic [DIV_W-1:0]  conv_clock_divider;
        logic              sleep_mode;
        logic              low_resolution_sel;
        logic [TSEL_W-1:0] trigger_source_sel;
        logic              hw_trigger_enable;
    } mode_cfg_t;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_PICK, ST_WAKE, ST_SAMPLE, ST_CONVERT, ST_STORE
    } seq_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

// ==== tb/adc_cell_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ========================
// analog cell stand-in
module adc_cell_model
    import adc_seq_pkg::*;
(
    // clock and cell controls
    input wire logic                ref_clk,
    input wire logic                cell_power_on,
    input wire logic                cell_sample,
    input wire logic [CH_IDX_W-1:0] cell_channel,
    // conversion value
    output logic [RES_W-1:0]        cell_result
);
    logic [RES_W-1:0] held_q;
    // track the selected input while sampling
    always_ff @(posedge ref_clk) begin
        if (cell_sample) held_q <= {cell_channel, 7'h2b};
    end
    // a powered-down cell gives no valid value
    assign cell_result = cell_power_on ? held_q : ~held_q;
endmodule : adc_cell_model
`default_nettype wire

// ==== tb/adc_seq_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
// ========================
// port checks for the sequencer
module adc_seq_assertions
    import adc_seq_pkg::*;
#(
    parameter int N_CH = NUM_CH
)
(
    // clock and reset
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    // controls and read strobes
    input wire logic                sw_start,
    input wire mode_cfg_t           mode_cfg,
    input wire logic [STAT_W-1:0]   irq_mask,
    input wire logic [N_CH-1:0]     channel_result_rd,
    input wire logic                last_result_rd,
    input wire logic                status_rd,
    // results and flags
    input wire logic [CH_IDX_W-1:0] last_channel,
    input wire logic [N_CH-1:0]     channel_conv_done,
    input wire logic [N_CH-1:0]     channel_overrun_flag,
    input wire logic                result_ready_flag,
    input wire logic                global_overrun_flag,
    input wire logic                busy,
    input wire logic                irq,
    input wire logic                dma_req,
    input wire logic                dma_size_16
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // flags in interrupt mask order
    wire logic [STAT_W-1:0] flags = {global_overrun_flag, result_ready_flag,
                                     channel_overrun_flag, channel_conv_done};
    // start taken while idle, channel, last and status reads while idle
    sequence s_start;
        sw_start && !busy;
    endsequence
    sequence s_idle;
        !busy && !sw_start;
    endsequence
    chk_start_raises_busy: assert property (s_start |=> busy)
        else $error("busy did not follow a start");
    chk_dma_on_ready: assert property (
        dma_req == $rose(result_ready_flag))
        else $error("dma request not tied to ready rising");
    chk_ready_sets_done: assert property (
        $rose(result_ready_flag) |-> channel_conv_done[last_channel])
        else $error("ready rose without channel done");
    chk_dma_size_res: assert property (
        dma_size_16 == !$past(mode_cfg.low_resolution_sel))
        else $error("dma size does not follow resolution");
    chk_chan_read_clr: assert property (
        (s_idle and ##0 (|channel_result_rd))
        |=> (channel_conv_done & $past(channel_result_rd)) == '0)
        else $error("channel read left its done flag");
    chk_last_read_clr: assert property (
        (s_idle and ##0 last_result_rd)
        |=> !result_ready_flag && !channel_conv_done[last_channel])
        else $error("last read left ready or done");
    chk_status_read_clr: assert property ((s_idle and ##0 status_rd)
        |=> channel_overrun_flag == '0 && !global_overrun_flag)
        else $error("status read left an overrun flag");
    chk_irq_from_flags: assert property (
        irq == $past(|(flags & irq_mask)))
        else $error("irq does not follow masked flags");
endmodule : adc_seq_assertions
bind adc_sequencer adc_seq_assertions #(.N_CH(N_CH))
    adc_seq_assertions_inst (.*);
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// ========================
// sequencer bench
module tb
    import adc_seq_pkg::*;
;
    // stimulus
    logic            ref_clk = 1'h0, sys_rst = 1'h1, sw_start = 1'h0;
    logic            last_result_rd = 1'h0, status_rd = 1'h0;
    logic            ext_trigger = 1'h0;
    mode_cfg_t       mode_cfg = '0;
    logic [7:0]      channel_enable_write = 8'h00;
    logic [7:0]      channel_disable_write = 8'h00;
    logic [7:0]      channel_result_rd = 8'h00;
    logic [5:0]      timer_wave_output = 6'h00;
    logic [17:0]     irq_mask = 18'h10000;
    // observed
    logic [9:0]      cell_result, last_result_value;
    logic [2:0]      cell_channel, last_channel;
    logic [7:0][9:0] channel_result_reg;
    logic [7:0]      channel_enabled, channel_conv_done, channel_overrun_flag;
    logic            cell_power_on, cell_clk_en, cell_sample, busy, irq;
    logic            result_ready_flag, global_overrun_flag;
    logic            dma_req, dma_size_16, samp_seen = 1'h0;
    int              n_mismatch = 0, total_checks = 0, n_dma = 0;
    int              n_samp = 0, n_clk = 0;
    logic [31:0]     order_w = 32'h0;
    adc_sequencer #(.N_CH(8)) adc_sequencer_inst (.*);
    adc_cell_model adc_cell_model_inst (.*);
    // free running clock
    always #25 ref_clk = ~ref_clk;
    // count dma pulses, record channel order of samples
    always @(posedge ref_clk) begin
        if (dma_req === 1'h1) n_dma++;
        if (cell_sample === 1'h1) n_samp++;
        if (cell_clk_en === 1'h1) n_clk++;
        if (cell_sample === 1'h1 && samp_seen !== 1'h1)
            order_w = {order_w[28:0], cell_channel};
        samp_seen = cell_sample;
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : step
    task automatic pulse(ref logic s);
        s = 1'h1;
        step(1);
        s = 1'h0;
    endtask : pulse
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // wait for a sequence to begin and end, bounded
    task automatic wait_idle();
        int k;
        for (k = 0; k < 8 && busy !== 1'h1; k++) step(1);
        if (busy === 1'h1) begin
            for (k = 0; k < 4000 && busy !== 1'h0; k++) step(1);
        end else begin
            k = 4000;   // sequence never began
        end
        if (k == 4000 || busy !== 1'h0) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : wait_idle
    // software start, optionally a second one while busy
    task automatic run_seq(input logic again);
        order_w = 32'h0;
        pulse(sw_start);
        if (again) begin
            step(8);
            pulse(sw_start);
        end
        wait_idle();
    endtask : run_seq
    // main sequence
    initial begin
        int k;
        repeat (6) @(posedge ref_clk);
        #2;
        sys_rst = 1'h0;
        step(1);
        check("size16", dma_size_16, 32'h1);
        channel_enable_write = 8'h4a;
        step(1);
        channel_enable_write = 8'h00;
        channel_disable_write = 8'h08;  // clears channel 3; disable writes are taken in any state
        step(1);
        channel_disable_write = 8'h00;
        check("enabled", channel_enabled, 32'h42);
        run_seq(1'h0);
        check("order", order_w, 32'h0e);
        check("cdr1", channel_result_reg[1], 32'h0ab);
        check("last", {last_channel, last_result_value}, 32'h1b2b);
        check("done", channel_conv_done, 32'h42);
        check("global_overrun_flag", global_overrun_flag, 32'h1);
        check("dma", n_dma, 32'h1);
        check("irq", irq, 32'h1);
        $display("test software sequence done");
        run_seq(1'h1);
        check("refused", order_w, 32'h0e);
        check("ovre", channel_overrun_flag, 32'h42);
        pulse(status_rd);
        check("ovr_clr", {global_overrun_flag, channel_overrun_flag}, 0);
        channel_result_rd = 8'h02;
        step(1);
        channel_result_rd = 8'h00;
        check("done_rd", channel_conv_done, 32'h40);
        pulse(last_result_rd);
        step(1);
        check("last_rd", {result_ready_flag, channel_conv_done}, 0);
        check("irq_off", irq, 32'h0);
        $display("test overrun and reads done");
        // one rising edge per source, each code 0..6 in turn, code 6 on the external pin
        mode_cfg.hw_trigger_enable = 1'h1;
        for (int c = 0; c < 7; c++) begin
            mode_cfg.trigger_source_sel = 3'(c);
            order_w = 32'h0;
            step(1);
            if (c == 6) ext_trigger = 1'h1;
            else timer_wave_output[c] = 1'h1;
            wait_idle();
            check("hw", order_w, 32'h0e);
            ext_trigger = 1'h0;
            timer_wave_output = 6'h00;
        end
        // code seven selects no source at all
        mode_cfg.trigger_source_sel = 3'h7;
        order_w = 32'h0;
        step(1);
        timer_wave_output = 6'h3f;
        ext_trigger = 1'h1;
        step(40);
        check("hw_none", order_w, 32'h0);
        timer_wave_output = 6'h00;
        ext_trigger = 1'h0;
        mode_cfg.trigger_source_sel = 3'h6;
        mode_cfg.hw_trigger_enable = 1'h0;
        order_w = 32'h0;
        step(1);
        ext_trigger = 1'h1;
        step(40);
        check("hw_off", order_w, 32'h0);
        mode_cfg.hw_trigger_enable = 1'h1;
        run_seq(1'h0);
        check("sw_with_hw", order_w, 32'h0e);
        ext_trigger = 1'h0;
        $display("test triggers done");
        mode_cfg.low_resolution_sel = 1'h1;
        mode_cfg.sample_hold_cycles = 4'h2;
        mode_cfg.conv_clock_divider = 6'h1;
        step(1);
        check("size8", dma_size_16, 32'h0);
        n_samp = 0;
        n_clk = 0;
        run_seq(1'h0);
        // two channels of (2+3)+10 ticks, four clocks each
        check("sh_len", n_samp, 32'h28);
        check("conv_len", n_clk, 32'h78);
        check("cdr6", channel_result_reg[6], 32'h02b);
        check("last8", last_result_value, 32'h02b);
        mode_cfg.low_resolution_sel = 1'h0;
        $display("test low resolution done");
        mode_cfg.sleep_mode = 1'h1;
        step(2);
        check("pwr_idle", cell_power_on, 32'h0);
        order_w = 32'h0;
        pulse(sw_start);
        for (k = 0; k < 500 && cell_sample !== 1'h1; k++) step(1);
        // one pick cycle, then eight ticks of four clocks
        check("wake", k, 32'h21);
        wait_idle();
        check("sleep_seq", order_w, 32'h0e);
        step(2);
        check("pwr_off", {cell_power_on, cell_clk_en}, 32'h0);
        $display("test sleep done");
        wrap_up();
    end
endmodule : tb
`default_nettype wire
